// ==== inc/opmode_pkg.sv ====
// Purpose: Shared constants and types for the operating-mode control block.
// Assumes: 8-bit registers on a plain strobe port, 25 MHz system clock.
// Notes: Offsets and interrupt register layout are local choices.
package opmode_pkg;
  // Register addresses on the plain port.
  localparam logic [3:0] ADDR_SYS_MODE = 4'h0;
  localparam logic [3:0] ADDR_AUX_MODE = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  // Field positions in system_mode_control.
  localparam int SYS_PRESCALE_LSB = 5;
  localparam int SYS_SLOW_RDY = 3;
  localparam int SYS_FAST_RDY = 2;
  localparam int SYS_IDLE_SEL = 1;
  localparam int SYS_FAST_SEL = 0;
  // Field positions in auxiliary_mode_control.
  localparam int AUX_SYSCLK_KEEP = 7;
  localparam int AUX_RESERVED = 3;
  localparam int AUX_LOWVOLT = 2;
  localparam int AUX_WDT_SWRST = 0;
  // Interrupt status bit positions.
  localparam int IRQ_FAST_RDY = 0;
  localparam int IRQ_SLOW_RDY = 1;
  localparam int IRQ_LOWVOLT = 2;
  localparam int IRQ_WDT_SWRST = 3;
  localparam int IRQ_WAKE = 4;
  localparam int IRQ_BITS = 5;
  // Reset values.
  localparam logic [2:0] PRESCALE_RST = 3'h0;
  localparam logic IDLE_SEL_RST = 1'b1;
  localparam logic FAST_SEL_RST = 1'b1;
  localparam logic SYSCLK_KEEP_RST = 1'b0;
  // Slow oscillator ready delay after wake-up: least 1, most 2 cycles.
  localparam int SLOW_RDY_DELAY_CYC = 2;
  // Power modes, one-hot.
  typedef enum logic [4:0] {
    MODE_RUN = 5'h01,
    MODE_IDLE_ON = 5'h02,
    MODE_IDLE_OFF = 5'h04,
    MODE_SLEEP = 5'h08,
    MODE_DEEP_SLEEP = 5'h10
  } power_mode_t;
endpackage

// ==== hdl/opmode_ctrl.sv ====
// Purpose: Operating-mode control bits, halt-mode selection and clock gating requests.
// Assumes: Reset and wake sources are on the system clock domain; oscillator stable levels are synchronised.
// Notes: One packed state struct, one combinational next-state process.
`timescale 1ns/1ps
module opmode_ctrl (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Register port.
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Events from the CPU, oscillators and reset logic.
  input wire logic halt_in,
  input wire logic wake_in,
  input wire logic wdt_off_in,
  input wire logic fast_osc_stable_in,
  input wire logic slow_osc_stable_in,
  input wire logic lowvolt_reset_in,
  input wire logic wdt_sw_reset_in,
  // Clock control outputs.
  output logic cpu_run_out,
  output logic sysclk_run_out,
  output logic fast_osc_enable_out,
  output logic sysclk_fast_out,
  output logic [2:0] prescale_sel_out,
  output opmode_pkg::power_mode_t power_mode_out,
  // Interrupt.
  output logic irq_out
);
  import opmode_pkg::*;

  typedef struct packed {
    logic [2:0] prescale;
    logic slow_rdy;
    logic fast_rdy;
    logic idle_sel;
    logic fast_sel;
    logic sysclk_keep;
    logic reserved;
    logic lowvolt;
    logic wdt_swrst;
    logic [1:0] wake_cnt;
    logic [1:0] fast_sync;
    logic [1:0] slow_sync;
    power_mode_t mode;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [7:0] rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;
  logic [IRQ_BITS-1:0] events;
  logic slow_is_sys;

  // System clock comes from the slow oscillator when fast select is clear and prescale picks it.
  assign slow_is_sys = !cur_ff.fast_sel && (cur_ff.prescale[2:1] == 2'b00);

  // Next-state logic: register writes, mode changes and flag updates.
  always_comb begin
    nxt_ff = cur_ff;
    events = '0;
    // Oscillator stable levels are from other clock sources: two flops first.
    nxt_ff.fast_sync = {cur_ff.fast_sync[0], fast_osc_stable_in};
    nxt_ff.slow_sync = {cur_ff.slow_sync[0], slow_osc_stable_in};
    // Fast ready follows the stable oscillator, and falls while it is stopped.
    nxt_ff.fast_rdy = cur_ff.fast_sync[1] && !slow_is_sys;
    if (nxt_ff.fast_rdy && !cur_ff.fast_rdy) begin
      events[IRQ_FAST_RDY] = 1'b1;
    end
    // Halt selects the low-power mode; wake returns to run.
    unique case (cur_ff.mode)
      MODE_RUN: begin
        if (halt_in) begin
          if (cur_ff.idle_sel) begin
            nxt_ff.mode = cur_ff.sysclk_keep ? MODE_IDLE_ON : MODE_IDLE_OFF;
          end else begin
            nxt_ff.mode = wdt_off_in ? MODE_DEEP_SLEEP : MODE_SLEEP;
          end
        end
      end
      MODE_IDLE_ON, MODE_IDLE_OFF, MODE_SLEEP, MODE_DEEP_SLEEP: begin
        if (wake_in) begin
          nxt_ff.mode = MODE_RUN;
          events[IRQ_WAKE] = 1'b1;
          if (cur_ff.mode == MODE_DEEP_SLEEP) begin
            nxt_ff.wake_cnt = 2'(SLOW_RDY_DELAY_CYC);
          end
        end
      end
      default: nxt_ff.mode = MODE_RUN;
    endcase
    // Slow ready: low from the cycle deep sleep is entered, rises after the wake delay.
    // Using the next mode keeps the flag from reading high in the first deep-sleep cycle.
    if (nxt_ff.mode == MODE_DEEP_SLEEP || cur_ff.mode == MODE_DEEP_SLEEP) begin
      nxt_ff.slow_rdy = 1'b0;
    end else if (cur_ff.wake_cnt != 2'h0) begin
      nxt_ff.wake_cnt = cur_ff.wake_cnt - 2'h1;
      if (cur_ff.wake_cnt == 2'h1) begin
        nxt_ff.slow_rdy = cur_ff.slow_sync[1];
        events[IRQ_SLOW_RDY] = cur_ff.slow_sync[1];
      end
    end else begin
      nxt_ff.slow_rdy = cur_ff.slow_sync[1];
    end
    // Register writes.
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_SYS_MODE: begin
          nxt_ff.prescale = reg_wdata_in[SYS_PRESCALE_LSB +: 3];
          nxt_ff.idle_sel = reg_wdata_in[SYS_IDLE_SEL];
          nxt_ff.fast_sel = reg_wdata_in[SYS_FAST_SEL];
        end
        ADDR_AUX_MODE: begin
          nxt_ff.sysclk_keep = reg_wdata_in[AUX_SYSCLK_KEEP];
          nxt_ff.reserved = reg_wdata_in[AUX_RESERVED];
          if (!reg_wdata_in[AUX_LOWVOLT]) begin
            nxt_ff.lowvolt = 1'b0;
          end
          if (!reg_wdata_in[AUX_WDT_SWRST]) begin
            nxt_ff.wdt_swrst = 1'b0;
          end
        end
        ADDR_IRQ_STATUS: nxt_ff.irq_status = cur_ff.irq_status & ~reg_wdata_in[IRQ_BITS-1:0];
        ADDR_IRQ_MASK: nxt_ff.irq_mask = reg_wdata_in[IRQ_BITS-1:0];
        default: ;
      endcase
    end
    // Hardware sets win over software clears.
    if (lowvolt_reset_in) begin
      nxt_ff.lowvolt = 1'b1;
      events[IRQ_LOWVOLT] = 1'b1;
    end
    if (wdt_sw_reset_in) begin
      nxt_ff.wdt_swrst = 1'b1;
      events[IRQ_WDT_SWRST] = 1'b1;
    end
    nxt_ff.irq_status = nxt_ff.irq_status | events;
    // Read data, valid the cycle after the read strobe.
    nxt_ff.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_SYS_MODE: nxt_ff.rdata = {cur_ff.prescale, 1'b0, cur_ff.slow_rdy, cur_ff.fast_rdy,
                                       cur_ff.idle_sel, cur_ff.fast_sel};
        ADDR_AUX_MODE: nxt_ff.rdata = {cur_ff.sysclk_keep, 3'h0, cur_ff.reserved, cur_ff.lowvolt,
                                       1'b0, cur_ff.wdt_swrst};
        ADDR_IRQ_STATUS: nxt_ff.rdata = 8'(cur_ff.irq_status);
        ADDR_IRQ_MASK: nxt_ff.rdata = 8'(cur_ff.irq_mask);
        default: nxt_ff.rdata = 8'h00;
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cur_ff <= '{prescale: PRESCALE_RST, slow_rdy: 1'b0, fast_rdy: 1'b0, idle_sel: IDLE_SEL_RST,
                  fast_sel: FAST_SEL_RST, sysclk_keep: SYSCLK_KEEP_RST, reserved: 1'b0,
                  lowvolt: 1'b0, wdt_swrst: 1'b0, wake_cnt: 2'h0, fast_sync: 2'h0, slow_sync: 2'h0,
                  mode: MODE_RUN, irq_status: '0, irq_mask: '0, rdata: 8'h00};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs derived from the registered state.
  assign reg_rdata_out = cur_ff.rdata;
  assign power_mode_out = cur_ff.mode;
  assign prescale_sel_out = cur_ff.prescale;
  assign sysclk_fast_out = cur_ff.fast_sel;
  assign cpu_run_out = (cur_ff.mode == MODE_RUN);
  assign sysclk_run_out = (cur_ff.mode == MODE_RUN) || (cur_ff.mode == MODE_IDLE_ON);
  assign fast_osc_enable_out = !slow_is_sys;
  assign irq_out = |(cur_ff.irq_status & cur_ff.irq_mask);
endmodule

// ==== test/opmode_ctrl_sva.sv ====
// Purpose: Concurrent checks on the mode control ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the design from the testbench top file.
`timescale 1ns/1ps
module opmode_ctrl_sva (
  // Clock, reset and register port.
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_rdata_out,
  // Mode and clock control.
  input wire logic halt_in,
  input wire logic wake_in,
  input wire logic cpu_run_out,
  input wire logic sysclk_run_out,
  input wire logic fast_osc_enable_out,
  input wire logic sysclk_fast_out,
  input wire logic [2:0] prescale_sel_out,
  input wire opmode_pkg::power_mode_t power_mode_out
);
  import opmode_pkg::*;
  // All checks share the system clock and its reset.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_halt_run; halt_in && power_mode_out == MODE_RUN; endsequence
  sequence s_wake_low; wake_in && power_mode_out != MODE_RUN; endsequence
  property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero after idle cycle");
  property p_aux_gap; reg_rd_in && reg_addr_in == ADDR_AUX_MODE |=> reg_rdata_out[6:4] == 3'h0; endproperty
  a_aux_gap: assert property (p_aux_gap) else $error("aux gap bits not zero");
  property p_idle_on; power_mode_out == MODE_IDLE_ON |-> !cpu_run_out && sysclk_run_out; endproperty
  a_idle_on: assert property (p_idle_on) else $error("idle clock-on gating wrong");
  property p_idle_off; power_mode_out == MODE_IDLE_OFF |-> !cpu_run_out && !sysclk_run_out; endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle clock-off gating wrong");
  property p_halt; s_halt_run |=> power_mode_out != MODE_RUN && !cpu_run_out; endproperty
  a_halt: assert property (p_halt) else $error("halt left device running");
  property p_wake; s_wake_low |=> power_mode_out == MODE_RUN; endproperty
  a_wake: assert property (p_wake) else $error("wake did not return to run");
  property p_hold; power_mode_out != MODE_RUN && !wake_in |=> $stable(power_mode_out); endproperty
  a_hold: assert property (p_hold) else $error("low power mode changed without wake");
  property p_slow; !sysclk_fast_out && prescale_sel_out[2:1] == 2'b00 |-> !fast_osc_enable_out; endproperty
  a_slow: assert property (p_slow) else $error("fast oscillator on with slow clock");
  property p_run; power_mode_out == MODE_RUN |-> cpu_run_out && sysclk_run_out; endproperty
  a_run: assert property (p_run) else $error("run mode clocks not on");
endmodule

// ==== test/test_opmode_ctrl.sv ====
// Purpose: Self-checking bench for the mode control block.
// Assumes: 25 MHz clock, strobe register port.
// Notes: One task per scenario.
`timescale 1ns/1ps
module test_opmode_ctrl;
  import opmode_pkg::*;
  logic sys_clk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, halt_in = 1'b0, wake_in = 1'b0;
  logic wdt_off_in = 1'b0, fast_osc_stable_in = 1'b0, slow_osc_stable_in = 1'b0;
  logic lowvolt_reset_in = 1'b0, wdt_sw_reset_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic cpu_run_out, sysclk_run_out, fast_osc_enable_out, sysclk_fast_out, irq_out;
  logic [2:0] prescale_sel_out;
  power_mode_t power_mode_out;
  int num_errors = 0, checks_done = 0, cyc = 0;
  opmode_ctrl opmode_ctrl_inst (.sys_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .halt_in, .wake_in, .wdt_off_in, .fast_osc_stable_in, .slow_osc_stable_in, .lowvolt_reset_in,
    .wdt_sw_reset_in, .cpu_run_out, .sysclk_run_out, .fast_osc_enable_out, .sysclk_fast_out, .prescale_sel_out,
    .power_mode_out, .irq_out);
  // Clock generation.
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in) reg_wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in) reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out & m, e);
    @(posedge sys_clk_in);
  endtask
  task automatic t_power();
    rd(ADDR_SYS_MODE, 8'h03, 8'hF7);
    fast_osc_stable_in <= 1'b1;
    slow_osc_stable_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    rd(ADDR_SYS_MODE, 8'h07, 8'hF7);
    wr(ADDR_IRQ_MASK, 8'h01);
    chk({7'h00, irq_out}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    chk({7'h00, irq_out}, 8'h00);
    rd(4'hF, 8'h00, 8'hFF);
  endtask
  task automatic t_flags();
    lowvolt_reset_in <= 1'b1;
    wdt_sw_reset_in <= 1'b1;
    @(posedge sys_clk_in) lowvolt_reset_in <= 1'b0;
    wdt_sw_reset_in <= 1'b0;
    @(posedge sys_clk_in);
    rd(ADDR_AUX_MODE, 8'h05, 8'hFF);
    wr(ADDR_AUX_MODE, 8'hFF);
    rd(ADDR_AUX_MODE, 8'h8D, 8'hFF);
    wr(ADDR_AUX_MODE, 8'h00);
    rd(ADDR_AUX_MODE, 8'h00, 8'hFF);
    wr(ADDR_IRQ_MASK, 8'h0C);
    chk({7'h00, irq_out}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h0C);
    chk({7'h00, irq_out}, 8'h00);
  endtask
  task automatic t_modes();
    logic [4:0] e;
    for (int i = 0; i < 4; i++) begin
      e = i[1] ? (i[0] ? MODE_IDLE_ON : MODE_IDLE_OFF) : (i[0] ? MODE_DEEP_SLEEP : MODE_SLEEP);
      wr(ADDR_SYS_MODE, {6'h00, i[1], 1'b1});
      wr(ADDR_AUX_MODE, {i[0], 7'h00});
      wdt_off_in <= i[0];
      halt_in <= 1'b1;
      @(posedge sys_clk_in) halt_in <= 1'b0;
      #1 chk({3'h0, power_mode_out}, {3'h0, e});
      if (i == 1) rd(ADDR_SYS_MODE, 8'h00, 8'h08);
      wake_in <= 1'b1;
      @(posedge sys_clk_in) wake_in <= 1'b0;
      #1 chk({3'h0, power_mode_out}, {3'h0, MODE_RUN});
      repeat (3) @(posedge sys_clk_in);
      if (i == 1) rd(ADDR_SYS_MODE, 8'h08, 8'h08);
    end
  endtask
  task automatic t_slow();
    wr(ADDR_SYS_MODE, 8'h00);
    chk({3'h0, prescale_sel_out, sysclk_fast_out, fast_osc_enable_out}, 8'h00);
    wr(ADDR_SYS_MODE, 8'h40);
    chk({3'h0, prescale_sel_out, sysclk_fast_out, fast_osc_enable_out}, 8'h09);
  endtask
  // Hang guard on the cycle count.
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    t_power();
    t_flags();
    t_modes();
    t_slow();
    complete_run();
  end
endmodule
bind opmode_ctrl opmode_ctrl_sva opmode_ctrl_sva_inst (.sys_clk_in, .srst_in, .reg_rd_in, .reg_addr_in,
  .reg_rdata_out, .halt_in, .wake_in, .cpu_run_out, .sysclk_run_out, .fast_osc_enable_out, .sysclk_fast_out,
  .prescale_sel_out, .power_mode_out);
